// ### hw/dram_page_ctl.sv
// Behaviour
// - Row strobe fall starts every read and write cycle
// - Keep row strobe low for row-active minimum
// - Row 8 bits first, then 9-bit column
// - Write line high throughout means read
// - Data valid by later write/column fall
// - Late write: gate high, wait gate-to-data
// - Issue 256 refreshes every 8 ms
// - Column low before row starts refresh
// - Page mode: row held, columns repeated
// - Wait 200 us, then eight row cycles
`timescale 1ns/10ps
`default_nettype none
module dram_page_ctl
   import dram_ctl_pkg::*;
#(
   parameter int POWERUP_WAIT = POWERUP_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_req_valid,
   input wire req_t i_req,
   output logic o_req_ready,
   output logic [DATA_W-1:0] o_rdata,
   output logic o_rdata_valid,
   output logic o_init_done,
   output pins_t o_dram,
   input wire logic [DATA_W-1:0] i_dq
);

   typedef enum logic [3:0] {
      S_IDLE,
      S_RAS,
      S_ROW,
      S_COL,
      S_CAS,
      S_OEOFF,
      S_LWDATA,
      S_LWE,
      S_END,
      S_PAGE,
      S_PRE,
      S_CBR_CAS,
      S_CBR_RAS
   } state_t;

   state_t state_r, state_nxt;
   pins_t pins_r, pins_nxt;
   req_t req_r, req_nxt;
   logic have_req_r, have_req_nxt;
   logic ready_r, ready_nxt;
   logic ref_pend_r, ref_pend_nxt;
   logic [CNT_W-1:0] init_cnt_r, init_cnt_nxt;
   logic init_done_r, init_done_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic page_r, page_nxt;
   logic col_load;
   logic [AGE_W-1:0] ras_age_r, ras_age_nxt;
   logic [AGE_W-1:0] cas_age_r, cas_age_nxt;
   logic [AGE_W-1:0] col_age_r, col_age_nxt;
   logic [AGE_W-1:0] oe_age_r, oe_age_nxt;
   logic [AGE_W-1:0] pre_age_r, pre_age_nxt;
   logic power_done;
   logic refresh_tick;
   logic data_ok;
   logic take;

   dram_refresh_timer #(
      .POWERUP_WAIT(POWERUP_WAIT)
   ) u_timer (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .o_power_done(power_done),
      .o_refresh_tick(refresh_tick)
   );

   // True once n cycles have passed since the age counter was cleared
   function automatic logic waited(logic [AGE_W-1:0] age, int n);
      return (int'(age) + 1 >= n);
   endfunction

   function automatic logic [AGE_W-1:0] age_step(logic [AGE_W-1:0] age, logic clr);
      if (clr) begin
         return '0;
      end
      return (&age) ? age : age + 1'b1;
   endfunction

   function automatic logic [PIN_ADDR_W-1:0] row_of(req_t r);
      return {1'b0, r.addr[ADDR_W-1:COL_W]};
   endfunction

   // Column phase pins: gate, write line and data chosen per command
   function automatic pins_t col_pins(pins_t p, req_t r);
      pins_t q;
      q = p;
      q.addr = r.addr[COL_W-1:0];
      q.we_n = (r.cmd == CMD_WRITE) ? 1'b0 : 1'b1;
      q.oe_n = (r.cmd == CMD_READ || r.cmd == CMD_RMW) ? 1'b0 : 1'b1;
      q.dq_oe = (r.cmd == CMD_WRITE);
      q.dq_out = r.wdata;
      return q;
   endfunction

   // Read data usable only when every access delay has run out
   assign data_ok = waited(ras_age_r, ROW_ACCESS_CYC)
                    && waited(cas_age_r, COL_STROBE_ACCESS_CYC)
                    && waited(col_age_r, COL_ADDR_ACCESS_CYC)
                    && waited(oe_age_r, GATE_ACCESS_CYC)
                    && (!page_r || waited(pre_age_r, COL_PRECHARGE_ACCESS_CYC));
   assign take = i_req_valid && ready_r;

   // Main sequencer; pins_nxt is what the pins show in the next state
   always_comb begin
      state_nxt = state_r;
      pins_nxt = pins_r;
      req_nxt = req_r;
      have_req_nxt = have_req_r;
      ref_pend_nxt = ref_pend_r;
      init_cnt_nxt = init_cnt_r;
      init_done_nxt = init_done_r;
      rdata_nxt = rdata_r;
      rvalid_nxt = 1'b0;
      cnt_nxt = cnt_r;
      page_nxt = page_r;
      col_load = 1'b0;
      unique case (state_r)
         S_IDLE: begin
            if (take) begin
               req_nxt = i_req;
               pins_nxt.addr = row_of(i_req);
               state_nxt = S_RAS;
            end else if (power_done && (ref_pend_r || !init_done_r)) begin
               pins_nxt.cas_n = 1'b0;
               pins_nxt.dq_oe = 1'b0;
               state_nxt = S_CBR_CAS;
            end
         end
         S_RAS: begin
            pins_nxt.ras_n = 1'b0;
            page_nxt = 1'b0;
            state_nxt = S_ROW;
         end
         S_ROW: begin
            pins_nxt = col_pins(pins_r, req_r);
            col_load = 1'b1;
            state_nxt = S_COL;
         end
         S_COL: begin
            pins_nxt.cas_n = 1'b0;
            state_nxt = S_CAS;
         end
         S_CAS: begin
            unique case (req_r.cmd)
               CMD_READ, CMD_RMW: begin
                  if (data_ok) begin
                     rdata_nxt = i_dq;
                     rvalid_nxt = 1'b1;
                     pins_nxt.oe_n = 1'b1;
                     cnt_nxt = '0;
                     if (req_r.cmd == CMD_READ) begin
                        pins_nxt.cas_n = 1'b1;
                        state_nxt = S_END;
                     end else begin
                        state_nxt = S_OEOFF;
                     end
                  end
               end
               CMD_LATE_WRITE: begin
                  cnt_nxt = '0;
                  state_nxt = S_OEOFF;
               end
               CMD_WRITE: begin
                  if (waited(cas_age_r, CAS_PULSE_CYC)) begin
                     pins_nxt.cas_n = 1'b1;
                     pins_nxt.we_n = 1'b1;
                     state_nxt = S_END;
                  end
               end
            endcase
         end
         S_OEOFF: begin
            // Drivers must be off before data goes out on the shared pins
            if (32'(cnt_r) + 1 >= GATE_TO_DATA_CYC) begin
               pins_nxt.dq_oe = 1'b1;
               pins_nxt.dq_out = req_r.wdata;
               state_nxt = S_LWDATA;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         S_LWDATA: begin
            if (32'(cnt_r) + 1 >= INPUT_DATA_SETUP_CYC) begin
               pins_nxt.we_n = 1'b0;
               cnt_nxt = '0;
               state_nxt = S_LWE;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         S_LWE: begin
            if (32'(cnt_r) + 1 >= WRITE_PULSE_CYC) begin
               pins_nxt.cas_n = 1'b1;
               pins_nxt.we_n = 1'b1;
               state_nxt = S_END;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         S_END: begin
            // Data held one cycle past the strobes for hold time
            pins_nxt.dq_oe = 1'b0;
            if (req_r.keep_open && !ref_pend_r) begin
               state_nxt = S_PAGE;
            end else if (waited(ras_age_r, ROW_ACTIVE_MIN_CYC)) begin
               pins_nxt.ras_n = 1'b1;
               cnt_nxt = '0;
               state_nxt = S_PRE;
            end
         end
         S_PAGE: begin
            if (take && row_of(i_req) == row_of(req_r)) begin
               req_nxt = i_req;
               pins_nxt = col_pins(pins_r, i_req);
               col_load = 1'b1;
               page_nxt = 1'b1;
               state_nxt = S_COL;
            end else if (take || ref_pend_r) begin
               // Other row or refresh due: close, serve any taken request later
               req_nxt = take ? i_req : req_r;
               have_req_nxt = take;
               if (waited(ras_age_r, ROW_ACTIVE_MIN_CYC)) begin
                  pins_nxt.ras_n = 1'b1;
                  cnt_nxt = '0;
                  state_nxt = S_PRE;
               end else begin
                  state_nxt = S_END;
               end
            end
         end
         S_PRE: begin
            if (32'(cnt_r) + 1 >= ROW_PRECHARGE_CYC
                && 32'(cnt_r) + 1 >= COL_PRECHARGE_CYC) begin
               if (have_req_r) begin
                  have_req_nxt = 1'b0;
                  pins_nxt.addr = row_of(req_r);
                  state_nxt = S_RAS;
               end else begin
                  state_nxt = S_IDLE;
               end
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         S_CBR_CAS: begin
            pins_nxt.ras_n = 1'b0;
            state_nxt = S_CBR_RAS;
         end
         S_CBR_RAS: begin
            if (waited(ras_age_r, ROW_ACTIVE_MIN_CYC)) begin
               pins_nxt.ras_n = 1'b1;
               pins_nxt.cas_n = 1'b1;
               ref_pend_nxt = 1'b0;
               cnt_nxt = '0;
               if (!init_done_r) begin
                  init_cnt_nxt = init_cnt_r + 1'b1;
                  init_done_nxt = (32'(init_cnt_r) + 1 >= INIT_CYCLES);
               end
               state_nxt = S_PRE;
            end
         end
      endcase
      // A tick in the clearing cycle is kept
      if (refresh_tick && init_done_r) begin
         ref_pend_nxt = 1'b1;
      end
      ready_nxt = (state_nxt == S_IDLE && init_done_nxt && !ref_pend_nxt && !have_req_nxt)
                  || (state_nxt == S_PAGE && !ref_pend_nxt && !have_req_nxt);
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r <= S_IDLE;
         pins_r <= PINS_RESET;
         req_r <= '0;
         have_req_r <= 1'b0;
         ready_r <= 1'b0;
         ref_pend_r <= 1'b0;
         init_cnt_r <= '0;
         init_done_r <= 1'b0;
         rdata_r <= '0;
         rvalid_r <= 1'b0;
         cnt_r <= '0;
         page_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pins_r <= pins_nxt;
         req_r <= req_nxt;
         have_req_r <= have_req_nxt;
         ready_r <= ready_nxt;
         ref_pend_r <= ref_pend_nxt;
         init_cnt_r <= init_cnt_nxt;
         init_done_r <= init_done_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         cnt_r <= cnt_nxt;
         page_r <= page_nxt;
      end
   end

   // Edge ages of the strobes, measured from the registered pins
   always_comb begin
      ras_age_nxt = age_step(ras_age_r, pins_r.ras_n && !pins_nxt.ras_n);
      cas_age_nxt = age_step(cas_age_r, pins_r.cas_n && !pins_nxt.cas_n);
      pre_age_nxt = age_step(pre_age_r, !pins_r.cas_n && pins_nxt.cas_n);
      oe_age_nxt = age_step(oe_age_r, pins_r.oe_n && !pins_nxt.oe_n);
      col_age_nxt = age_step(col_age_r, col_load);
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ras_age_r <= '1;
         cas_age_r <= '1;
         pre_age_r <= '1;
         oe_age_r <= '1;
         col_age_r <= '1;
      end else begin
         ras_age_r <= ras_age_nxt;
         cas_age_r <= cas_age_nxt;
         pre_age_r <= pre_age_nxt;
         oe_age_r <= oe_age_nxt;
         col_age_r <= col_age_nxt;
      end
   end

   assign o_dram = pins_r;
   assign o_req_ready = ready_r;
   assign o_rdata = rdata_r;
   assign o_rdata_valid = rvalid_r;
   assign o_init_done = init_done_r;

endmodule // dram_page_ctl
`default_nettype wire

// ### hw/dram_ctl_pkg.sv
package dram_ctl_pkg;

   // Clock and widths
   localparam int CLK_PERIOD_NS = 40;
   localparam int ROW_W = 8;
   localparam int COL_W = 9;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int PIN_ADDR_W = 9;
   localparam int AGE_W = 3;
   localparam int CNT_W = 4;
   localparam int PWR_CNT_W = 16;
   localparam int REF_CNT_W = 10;

   // Device times in ns (power-up in us, refresh in ms), slowest speed grade
   localparam int T_ROW_ACTIVE_MIN_NS = 50;
   localparam int T_ROW_PRECHARGE_NS = 30;
   localparam int T_COL_PRECHARGE_NS = 7;
   localparam int T_GATE_ACCESS_NS = 14;
   localparam int T_ROW_ACCESS_NS = 50;
   localparam int T_COL_ADDR_ACCESS_NS = 24;
   localparam int T_COL_STROBE_ACCESS_NS = 14;
   localparam int T_COL_PRECHARGE_ACCESS_NS = 27;
   localparam int T_GATE_TO_DATA_NS = 8;
   localparam int T_INPUT_DATA_SETUP_NS = 0;
   localparam int T_CAS_PULSE_NS = 9;
   localparam int T_WRITE_PULSE_NS = 7;
   localparam int T_POWERUP_US = 200;
   localparam int T_REFRESH_MS = 8;
   localparam int REFRESH_ROWS = 256;
   localparam int INIT_CYCLES = 8;

   // Least time: round up, never below one cycle
   function automatic int min_cycles(int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // Longest time: round down, never below one cycle
   function automatic int max_cycles(int ns);
      int c;
      c = ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int ROW_ACTIVE_MIN_CYC = min_cycles(T_ROW_ACTIVE_MIN_NS);
   localparam int ROW_PRECHARGE_CYC = min_cycles(T_ROW_PRECHARGE_NS);
   localparam int COL_PRECHARGE_CYC = min_cycles(T_COL_PRECHARGE_NS);
   localparam int GATE_ACCESS_CYC = min_cycles(T_GATE_ACCESS_NS);
   localparam int ROW_ACCESS_CYC = min_cycles(T_ROW_ACCESS_NS);
   localparam int COL_ADDR_ACCESS_CYC = min_cycles(T_COL_ADDR_ACCESS_NS);
   localparam int COL_STROBE_ACCESS_CYC = min_cycles(T_COL_STROBE_ACCESS_NS);
   localparam int COL_PRECHARGE_ACCESS_CYC = min_cycles(T_COL_PRECHARGE_ACCESS_NS);
   localparam int GATE_TO_DATA_CYC = min_cycles(T_GATE_TO_DATA_NS);
   localparam int INPUT_DATA_SETUP_CYC = min_cycles(T_INPUT_DATA_SETUP_NS);
   localparam int CAS_PULSE_CYC = min_cycles(T_CAS_PULSE_NS);
   localparam int WRITE_PULSE_CYC = min_cycles(T_WRITE_PULSE_NS);
   localparam int POWERUP_CYC = min_cycles(T_POWERUP_US * 1000);
   localparam int REFRESH_GAP_CYC = max_cycles(T_REFRESH_MS * 1000000 / REFRESH_ROWS);

   typedef enum logic [1:0] {
      CMD_READ,
      CMD_WRITE,
      CMD_LATE_WRITE,
      CMD_RMW
   } cmd_t;

   typedef struct packed {
      cmd_t cmd;
      logic keep_open;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } req_t;

   typedef struct packed {
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic oe_n;
      logic [PIN_ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic dq_oe;
   } pins_t;

   localparam pins_t PINS_RESET = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                    addr: 9'h000, dq_out: 8'h00, dq_oe: 1'b0};

endpackage

// ### hw/dram_refresh_timer.sv
`timescale 1ns/10ps
`default_nettype none
module dram_refresh_timer
   import dram_ctl_pkg::*;
#(
   parameter int POWERUP_WAIT = POWERUP_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   output logic o_power_done,
   output logic o_refresh_tick
);

   logic [PWR_CNT_W-1:0] pwr_cnt_r, pwr_cnt_nxt;
   logic [REF_CNT_W-1:0] ref_cnt_r, ref_cnt_nxt;
   logic done_r, done_nxt;
   logic tick_r, tick_nxt;

   // Power-up pause first, then one refresh slot per gap
   always_comb begin
      pwr_cnt_nxt = pwr_cnt_r;
      ref_cnt_nxt = ref_cnt_r;
      done_nxt = done_r;
      tick_nxt = 1'b0;
      if (!done_r) begin
         if (32'(pwr_cnt_r) + 1 >= POWERUP_WAIT) begin
            done_nxt = 1'b1;
         end else begin
            pwr_cnt_nxt = pwr_cnt_r + 1'b1;
         end
      end else if (32'(ref_cnt_r) + 1 >= REFRESH_GAP_CYC) begin
         ref_cnt_nxt = '0;
         tick_nxt = 1'b1;
      end else begin
         ref_cnt_nxt = ref_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pwr_cnt_r <= '0;
         ref_cnt_r <= '0;
         done_r <= 1'b0;
         tick_r <= 1'b0;
      end else begin
         pwr_cnt_r <= pwr_cnt_nxt;
         ref_cnt_r <= ref_cnt_nxt;
         done_r <= done_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign o_power_done = done_r;
   assign o_refresh_tick = tick_r;

endmodule // dram_refresh_timer
`default_nettype wire

// ### verification/dram_page_ctl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dram_page_ctl_checker
   import dram_ctl_pkg::*;
#(
   parameter int POWERUP_WAIT = POWERUP_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_req_valid,
   input wire req_t i_req,
   input wire logic o_req_ready,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic o_rdata_valid,
   input wire logic o_init_done,
   input wire pins_t o_dram,
   input wire logic [DATA_W-1:0] i_dq
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   int wait_r, wait_nxt, falls_r, falls_nxt;
   logic ras_r, ras_nxt;

   // Cycles since reset and row strobe falls; both saturate to stay small
   always_comb begin
      wait_nxt = (wait_r < 100000) ? wait_r + 1 : wait_r;
      falls_nxt = (ras_r && !o_dram.ras_n && falls_r < 15) ? falls_r + 1 : falls_r;
      ras_nxt = o_dram.ras_n;
   end

   // Registers only
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wait_r <= 0;
         falls_r <= 0;
         ras_r <= 1'b1;
      end else begin
         wait_r <= wait_nxt;
         falls_r <= falls_nxt;
         ras_r <= ras_nxt;
      end
   end

   sequence s_row_open;
      (!o_dram.ras_n) [*2];
   endsequence
   sequence s_cbr_start;
      $fell(o_dram.cas_n) && o_dram.ras_n;
   endsequence

   property p_ras_min;
      $fell(o_dram.ras_n) |-> s_row_open;
   endproperty
   a_ras_min: assert property (p_ras_min) else $error("row strobe pulse too short");
   property p_cbr;
      s_cbr_start |=> $fell(o_dram.ras_n);
   endproperty
   a_cbr: assert property (p_cbr) else $error("refresh row strobe late");
   property p_cbr_no_data;
      (!o_dram.cas_n && o_dram.ras_n) |-> !o_dram.dq_oe;
   endproperty
   a_cbr_no_data: assert property (p_cbr_no_data) else $error("data driven in refresh");
   property p_col_stable;
      ($fell(o_dram.cas_n) && !o_dram.ras_n) |-> $stable(o_dram.addr);
   endproperty
   a_col_stable: assert property (p_col_stable) else $error("column moved at strobe");
   property p_write_data;
      $fell(o_dram.we_n) |-> (o_dram.dq_oe && !o_dram.ras_n);
   endproperty
   a_write_data: assert property (p_write_data) else $error("write without data");
   property p_late_gate;
      ($fell(o_dram.we_n) && !o_dram.cas_n) |-> (o_dram.oe_n && $past(o_dram.dq_oe));
   endproperty
   a_late_gate: assert property (p_late_gate) else $error("late write gate order");
   property p_no_fight;
      !o_dram.oe_n |-> !o_dram.dq_oe;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("drive with gate low");
   property p_read_we;
      o_rdata_valid |-> o_dram.we_n;
   endproperty
   a_read_we: assert property (p_read_we) else $error("read with write low");
   property p_powerup;
      $fell(o_dram.ras_n) |-> (wait_r >= POWERUP_WAIT);
   endproperty
   a_powerup: assert property (p_powerup) else $error("row strobe before pause");
   property p_init_cycles;
      $rose(o_init_done) |-> (falls_r >= 8);
   endproperty
   a_init_cycles: assert property (p_init_cycles) else $error("too few init cycles");
   property p_ready_init;
      o_req_ready |-> o_init_done;
   endproperty
   a_ready_init: assert property (p_ready_init) else $error("ready before init");
endmodule // dram_page_ctl_checker

bind dram_page_ctl dram_page_ctl_checker #(.POWERUP_WAIT(POWERUP_WAIT)) chk_u (.i_clk,
   .i_reset_n, .i_req_valid, .i_req, .o_req_ready, .o_rdata, .o_rdata_valid, .o_init_done,
   .o_dram, .i_dq);
`default_nettype wire

// ### verification/dram_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module dram_dev_model
   import dram_ctl_pkg::*;
(
   input wire pins_t i_pins,
   input wire logic [DATA_W-1:0] i_dq,
   output logic [DATA_W-1:0] o_dq,
   output logic o_drive,
   output int o_refreshes
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [ROW_W-1:0] row;
   logic [COL_W-1:0] col, ref_row;
   logic ras_q, cas_q, we_q, cbr;

   initial begin
      {ras_q, cas_q, we_q, cbr, o_drive} = 5'h1C;
      {row, col, ref_row, o_dq} = 34'h0;
      o_refreshes = 0;
   end

   // Strobe edges; the 1 ns wait lets the controller's own pins settle first
   always @(i_pins.ras_n or i_pins.cas_n or i_pins.we_n or i_pins.oe_n) begin
      #1;
      if (ras_q && !i_pins.ras_n) begin
         cbr = !i_pins.cas_n;
         if (cbr) begin
            ref_row = ref_row + 9'h001;
            o_refreshes = o_refreshes + 1;
         end else begin
            row = i_pins.addr[ROW_W-1:0];
         end
      end
      if (cas_q && !i_pins.cas_n && !i_pins.ras_n && !cbr) begin
         col = i_pins.addr;
      end
      if (!i_pins.ras_n && !cbr && !i_pins.cas_n && !i_pins.we_n && (cas_q || we_q)) begin
         mem[{row, col}] = i_dq;
      end
      // Outputs need row, column strobe and gate, and no write
      o_drive = !i_pins.ras_n && !cbr && !i_pins.cas_n
                && i_pins.we_n && !i_pins.oe_n;
      o_dq <= #(T_COL_STROBE_ACCESS_NS - 1) mem[{row, col}];
      if (i_pins.ras_n) begin
         cbr = 1'b0;
      end
      ras_q = i_pins.ras_n;
      cas_q = i_pins.cas_n;
      we_q = i_pins.we_n;
   end
endmodule // dram_dev_model
`default_nettype wire

// ### verification/test_dram_page_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module test_dram_page_ctl;
   import dram_ctl_pkg::*;
   logic i_clk, i_reset_n, i_req_valid, o_req_ready, o_rdata_valid, o_init_done, dev_drv;
   req_t i_req;
   pins_t o_dram;
   logic [DATA_W-1:0] o_rdata, i_dq, dev_dq;
   logic [DATA_W-1:0] last_q = 8'h5A;
   int failures = 0, n_compared = 0, cycles = 0, refs;

   dram_page_ctl #(.POWERUP_WAIT(20)) dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_rdata(o_rdata),
      .o_rdata_valid(o_rdata_valid), .o_init_done(o_init_done), .o_dram(o_dram), .i_dq(i_dq));
   dram_dev_model dev_u (.i_pins(o_dram), .i_dq(i_dq), .o_dq(dev_dq), .o_drive(dev_drv),
      .o_refreshes(refs));

   // Undriven pins show a changing pattern, not a kept value
   assign i_dq = o_dram.dq_oe ? o_dram.dq_out : (dev_drv ? dev_dq : ~last_q);
   always @(posedge i_clk) last_q <= i_dq;

   initial begin
      i_clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;
   end

   // Hang guard, well above the few thousand cycles needed
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("[FAIL] run time expected below 20000 seen %0d", cycles);
         stop_test();
      end
   end

   task automatic stop_test();
      if (failures == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Hold the request until an edge sees ready high
   task automatic do_req(cmd_t c, logic keep, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      i_req_valid <= 1'b1;
      i_req <= '{cmd: c, keep_open: keep, addr: a, wdata: d};
      @(posedge i_clk);
      while (o_req_ready !== 1'b1 && n < 2000) begin
         @(posedge i_clk);
         n++;
      end
      i_req_valid <= 1'b0;
      check("request taken", 32'h1, {31'h0, o_req_ready === 1'b1});
   endtask

   task automatic read_chk(cmd_t c, logic keep, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d,
         logic [DATA_W-1:0] exp);
      int n;
      n = 0;
      do_req(c, keep, a, d);
      @(posedge i_clk);
      while (o_rdata_valid !== 1'b1 && n < 100) begin
         @(posedge i_clk);
         n++;
      end
      // A lost pulse must not hide behind stale data that happens to match
      check("read valid", 32'h1, {31'h0, o_rdata_valid === 1'b1});
      check("read data", {24'h0, exp}, {24'h0, o_rdata});
   endtask

   task automatic t_init();
      int n;
      n = 0;
      while (o_init_done !== 1'b1 && n < 2000) begin
         @(posedge i_clk);
         n++;
      end
      check("init done", 32'h1, {31'h0, o_init_done === 1'b1});
      check("init refreshes", 32'h1, {31'h0, refs >= 8});
   endtask

   task automatic t_early_write();
      logic [ADDR_W-1:0] a [4] = '{17'h00000, 17'h1FFFF, 17'h0A1FF, 17'h15100};
      logic [DATA_W-1:0] d [4] = '{8'h00, 8'hFF, 8'h5A, 8'hC3};
      for (int i = 0; i < 4; i++) do_req(CMD_WRITE, 1'b0, a[i], d[i]);
      for (int i = 0; i < 4; i++) read_chk(CMD_READ, 1'b0, a[i], 8'h00, d[i]);
   endtask

   task automatic t_late_and_rmw();
      do_req(CMD_LATE_WRITE, 1'b0, 17'h03003, 8'h96);
      read_chk(CMD_READ, 1'b0, 17'h03003, 8'h00, 8'h96);
      read_chk(CMD_RMW, 1'b0, 17'h0A1FF, 8'h3C, 8'h5A);
      read_chk(CMD_READ, 1'b0, 17'h0A1FF, 8'h00, 8'h3C);
   endtask

   task automatic t_page();
      for (int i = 0; i < 4; i++) begin
         do_req(CMD_WRITE, 1'b1, {8'h55, 9'(i * 85)}, 8'(8'h10 + i));
      end
      for (int i = 3; i >= 0; i--) begin
         read_chk(CMD_READ, 1'b1, {8'h55, 9'(i * 85)}, 8'h00, 8'(8'h10 + i));
      end
      read_chk(CMD_READ, 1'b0, 17'h1FFFF, 8'h00, 8'hFF);
   endtask

   task automatic t_refresh_rate();
      int r0;
      r0 = refs;
      repeat (2 * (8000000 / 256 / CLK_PERIOD_NS) + 40) @(posedge i_clk);
      check("refreshes in two gaps", 32'h1, {31'h0, (refs - r0) >= 2});
      read_chk(CMD_READ, 1'b0, 17'h15100, 8'h00, 8'hC3);
   endtask

   // Main sequence
   initial begin
      i_reset_n = 1'b0;
      i_req_valid = 1'b0;
      i_req = '0;
      repeat (20) @(posedge i_clk);
      i_reset_n <= 1'b1;
      t_init();
      t_early_write();
      t_late_and_rmw();
      t_page();
      t_refresh_rate();
      repeat (10) @(posedge i_clk);
      stop_test();
   end

   // Controller and device must never drive the data pins together
   always @(negedge i_clk) begin
      if (i_reset_n && o_dram.dq_oe && dev_drv) begin
         failures++;
         $display("[FAIL] data pin drivers expected one seen two");
      end
   end
endmodule // test_dram_page_ctl
`default_nettype wire
